// ===== rtl/shrp_regs.svh
`ifndef SHRP_REGS_SVH
`define SHRP_REGS_SVH
// bus addresses and command bytes
`define SHRP_OWN_ADDR 7'h5a
`define SHRP_GCALL_ADDR 7'h00
`define SHRP_GCALL_RESET 8'h06
// pointer byte fields
`define SHRP_PTR_HOLD_BIT 6
`define SHRP_PTR_MSB 5
// register file
`define SHRP_REG_COUNT 64
`define SHRP_CMD_REG 6'h18
`define SHRP_REG_RESET 8'h00
// ticks of ref_clk spent in the initialization phase after a reset
`define SHRP_INIT_CYCLES 16'h0040
`endif

// ===== rtl/shrp_pkg.sv
package shrp_pkg;
  typedef enum logic [2:0] {
    SHRP_IDLE, SHRP_ADDR, SHRP_PTR, SHRP_WDATA, SHRP_GCMD, SHRP_RDATA, SHRP_ACK, SHRP_RACK
  } shrp_state_t;
  typedef enum logic [1:0] {SHRP_OFF, SHRP_INIT, SHRP_READY} shrp_mode_t;
  // one access towards the register memory
  typedef struct packed {
    logic we;
    logic [5:0] addr;
    logic [7:0] wdata;
  } shrp_mem_req_t;
endpackage : shrp_pkg

// ===== rtl/shrp_regmem.sv
`timescale 1ns/1ps
`include "shrp_regs.svh"
module shrp_regmem
  import shrp_pkg::*;
#(
  parameter int DEPTH = `SHRP_REG_COUNT
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire shrp_mem_req_t req,
  output logic [7:0] rdata
);
  logic [7:0] mem [DEPTH];
  // contents are cleared by reset so a general-call reset restores defaults
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) mem[i] <= `SHRP_REG_RESET;
      rdata <= `SHRP_REG_RESET;
    end else begin
      if (req.we) mem[req.addr] <= req.wdata;
      rdata <= mem[req.addr];
    end
  end
endmodule : shrp_regmem

// ===== rtl/shrp_port.sv
`timescale 1ns/1ps
`include "shrp_regs.svh"
// Overview of operation
// - the block answers only to 7-bit address 0x5a and the general-call address 0x00, and never to 10-bit addressing.
// - the general-call address 0x00 is acknowledged and its command byte 0x06 resets the block.
// - in a write the first byte is address, the second loads the pointer, later bytes store.
// - in a read the block drives the register chosen by the pointer for each byte.
// - burst reads and writes walk across contiguous registers in one transfer.
// - pointer bits 5..0 pick the register, bit 6 holds the pointer, bit 7 is zero.
// - the pointer advances after each byte unless the hold flag was set.
// - the interrupt line is only ever pulled low, never driven high.
// - from the cycle after the off state is entered the bus and interrupt pins are released.
// - the general-call reset puts the block off and then straight into initialization.
// - register accesses do not wake the sequencer, except a write to the command register.
module shrp_port
  import shrp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic scl_out,
  output logic scl_oe,
  input wire logic irq_req,
  output logic int_out,
  output logic int_oe,
  input wire logic off_cmd,
  output logic seq_wake,
  output logic [7:0] seq_cmd,
  output logic init_busy
);
  localparam logic [15:0] INIT_CYCLES = `SHRP_INIT_CYCLES;

  // ****************************************
  // pin sampling
  // ****************************************
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  always_ff @(posedge ref_clk) begin
    scl_s1 <= scl_in;
    scl_s2 <= scl_s1;
    scl_d <= scl_s2;
    sda_s1 <= sda_in;
    sda_s2 <= sda_s1;
    sda_d <= sda_s2;
  end
  wire scl_rise = scl_s2 & ~scl_d;
  wire scl_fall = ~scl_s2 & scl_d;
  wire start_seen = scl_s2 & scl_d & sda_d & ~sda_s2;
  wire stop_seen = scl_s2 & scl_d & ~sda_d & sda_s2;

  // ****************************************
  // mode control
  // ****************************************
  shrp_mode_t mode;
  logic [15:0] init_cnt;
  logic gc_reset;
  wire bus_live = (mode == SHRP_READY);
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      mode <= SHRP_INIT;
      init_cnt <= '0;
    end else begin
      case (mode)
        SHRP_OFF: begin
          mode <= SHRP_INIT;
          init_cnt <= '0;
        end
        SHRP_INIT: begin
          init_cnt <= init_cnt + 16'h0001;
          if (init_cnt == INIT_CYCLES - 16'h0001) mode <= SHRP_READY;
        end
        SHRP_READY: begin
          if (gc_reset || off_cmd) mode <= SHRP_OFF;
        end
        default: mode <= SHRP_OFF;
      endcase
      if (off_cmd && mode != SHRP_READY) mode <= SHRP_OFF;
    end
  end
  // off_cmd held high keeps the block parked in off; init restarts from count zero on release

  // ****************************************
  // byte engine
  // ****************************************
  shrp_state_t state, after_ack;
  logic [7:0] shreg;
  logic [2:0] bitn;
  logic [5:0] ptr;
  logic hold_ptr, gc_armed, drive_low, ack_pending;
  logic [7:0] rdata;
  shrp_mem_req_t mreq;
  // registers return to their defaults on a general-call reset as well
  wire mem_rst_b = rst_b & ~gc_reset;
  wire byte_done = scl_rise && bitn == 3'd7;
  wire [7:0] rx_byte = {shreg[6:0], sda_s2};
  wire own_hit = rx_byte[7:1] == `SHRP_OWN_ADDR;
  wire gc_hit = rx_byte[7:1] == `SHRP_GCALL_ADDR && !rx_byte[0];
  wire [5:0] ptr_next = hold_ptr ? ptr : ptr + 6'h01;
  wire wr_byte = state == SHRP_WDATA && byte_done;
  assign mreq.we = wr_byte;
  assign mreq.addr = ptr;
  assign mreq.wdata = rx_byte;

  shrp_regmem #(.DEPTH(`SHRP_REG_COUNT)) u_mem (
    .ref_clk(ref_clk),
    .rst_b(mem_rst_b),
    .req(mreq),
    .rdata(rdata)
  );

  always_ff @(posedge ref_clk) begin
    if (!rst_b || !bus_live) begin
      state <= SHRP_IDLE;
      after_ack <= SHRP_IDLE;
      shreg <= 8'h00;
      bitn <= 3'd0;
      ptr <= 6'h00;
      hold_ptr <= 1'b0;
      gc_armed <= 1'b0;
      drive_low <= 1'b0;
      gc_reset <= 1'b0;
      ack_pending <= 1'b0;
    end else begin
      gc_reset <= 1'b0;
      if (start_seen) begin
        state <= SHRP_ADDR;
        bitn <= 3'd0;
        drive_low <= 1'b0;
        gc_armed <= 1'b0;
      end else if (stop_seen) begin
        state <= SHRP_IDLE;
        drive_low <= 1'b0;
      end else begin
        if (scl_rise) begin
          shreg <= rx_byte;
          bitn <= bitn + 3'd1;
        end
        case (state)
          SHRP_ADDR: if (byte_done) begin
            if (own_hit) after_ack <= rx_byte[0] ? SHRP_RDATA : SHRP_PTR;
            else if (gc_hit) after_ack <= SHRP_GCMD;
            ack_pending <= own_hit | gc_hit;
            state <= (own_hit | gc_hit) ? SHRP_ACK : SHRP_IDLE;
          end
          SHRP_PTR: if (byte_done) begin
            ptr <= rx_byte[`SHRP_PTR_MSB:0];
            hold_ptr <= rx_byte[`SHRP_PTR_HOLD_BIT];
            ack_pending <= 1'b1;
            after_ack <= SHRP_WDATA;
            state <= SHRP_ACK;
          end
          SHRP_WDATA: if (byte_done) begin
            ptr <= ptr_next;
            ack_pending <= 1'b1;
            after_ack <= SHRP_WDATA;
            state <= SHRP_ACK;
          end
          SHRP_GCMD: if (byte_done) begin
            gc_armed <= rx_byte == `SHRP_GCALL_RESET;
            ack_pending <= 1'b1;
            after_ack <= SHRP_IDLE;
            state <= SHRP_ACK;
          end
          SHRP_ACK: begin
            if (scl_fall && ack_pending) begin
              drive_low <= 1'b1;
              ack_pending <= 1'b0;
            end else if (scl_fall) begin
              drive_low <= after_ack == SHRP_RDATA ? ~rdata[7] : 1'b0;
              // reset only after the ack clock, so the host still sees the byte taken
              gc_reset <= gc_armed;
              gc_armed <= 1'b0;
              shreg <= rdata;
              bitn <= 3'd0;
              state <= after_ack;
            end
          end
          SHRP_RDATA: if (scl_fall) begin
            // shreg shifts on every rise, so the next bit out is always in bit 7
            drive_low <= bitn == 3'd0 ? 1'b0 : ~shreg[7];
            if (bitn == 3'd0) begin
              state <= SHRP_RACK;
              ptr <= ptr_next;
            end
          end
          SHRP_RACK: if (scl_rise) begin
            bitn <= 3'd0;
            // host nack ends the read
            state <= sda_s2 ? SHRP_IDLE : SHRP_ACK;
            after_ack <= SHRP_RDATA;
          end
          default: state <= SHRP_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // pins and sequencer hooks
  // ****************************************
  // only command writes wake
  wire cmd_write = wr_byte && ptr == `SHRP_CMD_REG;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      scl_out <= 1'b0;
      scl_oe <= 1'b0;
      int_out <= 1'b0;
      int_oe <= 1'b0;
      seq_wake <= 1'b0;
      seq_cmd <= 8'h00;
      init_busy <= 1'b1;
    end else begin
      sda_oe <= drive_low & bus_live;
      int_oe <= irq_req & bus_live;
      seq_wake <= cmd_write;
      if (cmd_write) seq_cmd <= rx_byte;
      init_busy <= mode != SHRP_READY;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  own_addr_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (state == SHRP_ADDR && byte_done && !own_hit && !gc_hit) |=> state == SHRP_IDLE)
    else $error("foreign address not ignored");
  gcall_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    gc_reset |=> mode == SHRP_OFF)
    else $error("general call reset not taken");
  ptr_load_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (state == SHRP_PTR && byte_done && !start_seen && !stop_seen && bus_live)
    |=> ptr == shreg[5:0] && hold_ptr == shreg[6])
    else $error("pointer not loaded");
  ptr_walk_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (wr_byte && !start_seen && !stop_seen && bus_live) |=> ptr == $past(ptr_next))
    else $error("pointer step wrong");
  int_low_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    int_out == 1'b0 && scl_out == 1'b0 && sda_out == 1'b0)
    else $error("pin driven high");
  off_release_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    mode == SHRP_OFF |=> !sda_oe && !int_oe)
    else $error("pins not released");
  reset_init_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    mode == SHRP_OFF && !off_cmd |=> mode == SHRP_INIT ##1 init_busy)
    else $error("off not followed by init");
  wake_cmd_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    seq_wake |-> $past(cmd_write))
    else $error("wake without command write");
  ack_drive_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (state == SHRP_ACK && scl_fall && ack_pending) |=> drive_low ##1 sda_oe)
    else $error("ack not driven");
  wr_cov_c: cover property (@(posedge ref_clk) wr_byte);
  rd_cov_c: cover property (@(posedge ref_clk) state == SHRP_RACK);
  gc_cov_c: cover property (@(posedge ref_clk) gc_reset);
endmodule : shrp_port

// ===== dv/shrp_host_bfm.sv
`timescale 1ns/1ps
module shrp_host_bfm (
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  // ****
  // host master, scl stands high between frames
  // ****
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic start_c;
    sda_pull = 1'b0;
    #12;
    scl = 1'b1;
    #24;
    sda_pull = 1'b1;
    #24;
    scl = 1'b0;
    #12;
  endtask : start_c
  task automatic stop_c;
    sda_pull = 1'b1;
    #12;
    scl = 1'b1;
    #24;
    sda_pull = 1'b0;
    #24;
  endtask : stop_c
  // long low phase leaves the target time to turn sda round
  task automatic bit_c(input logic b, output logic r);
    sda_pull = !b;
    #24;
    scl = 1'b1;
    r = sda;
    #12;
    scl = 1'b0;
    #12;
  endtask : bit_c
  // ninth bit: release for ack, or nack the last read
  task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_c(tx[i], r);
      rx[i] = r;
    end
    bit_c(last, r);
    ack = !r;
  endtask : xfer
endmodule : shrp_host_bfm

// ===== dv/sensor_host_register_port_tb.sv
`timescale 1ns/1ps
`include "shrp_regs.svh"
module sensor_host_register_port_tb;
  import shrp_pkg::*;
  logic ref_clk, rst_b, irq_req, off_cmd, sda_out, sda_oe, scl_out, scl_oe;
  logic int_out, int_oe, seq_wake, init_busy, scl_h, pull, scl_w, sda_w, a;
  logic [7:0] seq_cmd, rx;
  logic [6:0] bad [3] = '{7'h5b, 7'h2d, 7'h78};
  int n_errors = 0, n_tests = 0, n_wake = 0, exp_wake = 0, cyc = 0, ptr;
  int mem [64];
  logic hold;
  // ****
  // wiring, model and checks
  // ****
  assign scl_w = scl_h & ~scl_oe;
  assign sda_w = ~(sda_oe | pull);
  shrp_port uut (.ref_clk(ref_clk), .rst_b(rst_b), .scl_in(scl_w), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out), .scl_oe(scl_oe), .irq_req(irq_req),
    .int_out(int_out), .int_oe(int_oe), .off_cmd(off_cmd), .seq_wake(seq_wake),
    .seq_cmd(seq_cmd), .init_busy(init_busy));
  shrp_host_bfm u_host (.sda(sda_w), .scl(scl_h), .sda_pull(pull));
  initial ref_clk = 1'b0;
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (seq_wake === 1'b1) n_wake++;
    if (cyc == 40000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  task automatic check_byte(input string w, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask : check_byte
  task automatic check_bit(input string w, input logic e, input logic g);
    check_byte(w, {7'h00, e}, {7'h00, g});
  endtask : check_bit
  task automatic send(input logic [7:0] b, input logic ea);
    u_host.xfer(b, 1'b1, rx, a);
    check_bit("ack", ea, a);
  endtask : send
  task automatic wait_ready;
    int k = 0;
    repeat (4) @(negedge ref_clk);
    while (init_busy !== 1'b0 && k < 300) begin
      @(negedge ref_clk);
      k++;
    end
    check_bit("init_busy", 1'b0, init_busy);
  endtask : wait_ready
  task automatic set_ptr(input logic [7:0] p);
    u_host.start_c();
    send({`SHRP_OWN_ADDR, 1'b0}, 1'b1);
    send(p, 1'b1);
    ptr = int'(p[5:0]);
    hold = p[6];
  endtask : set_ptr
  task automatic step;
    if (!hold) ptr = (ptr + 1) % 64;
  endtask : step
  task automatic wr(input logic [7:0] p, input int n);
    logic [7:0] d;
    set_ptr(p);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      send(d, 1'b1);
      mem[ptr] = int'(d);
      if (ptr == int'(`SHRP_CMD_REG)) exp_wake++;
      step();
    end
    u_host.stop_c();
  endtask : wr
  task automatic rd(input logic [7:0] p, input int n);
    set_ptr(p);
    u_host.start_c();
    send({`SHRP_OWN_ADDR, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      u_host.xfer(8'hff, i == n - 1, rx, a);
      check_byte("rdata", 8'(mem[ptr]), rx);
      step();
    end
    u_host.stop_c();
  endtask : rd
  task automatic gcall;
    u_host.start_c();
    send({`SHRP_GCALL_ADDR, 1'b0}, 1'b1);
    send(`SHRP_GCALL_RESET, 1'b1);
    u_host.stop_c();
    foreach (mem[i]) mem[i] = 0;
    wait_ready();
  endtask : gcall
  // ****
  // scenarios
  // ****
  initial begin
    void'($urandom(16971));
    rst_b = 1'b0;
    irq_req = 1'b0;
    off_cmd = 1'b0;
    foreach (mem[i]) mem[i] = 0;
    repeat (5) @(negedge ref_clk);
    rst_b = 1'b1;
    wait_ready();
    gcall();
    wr(8'h3e, 3);
    rd(8'h3e, 3);
    gcall();
    rd(8'h3e, 3);
    wr(8'h10, 10);
    rd(8'h10, 10);
    wr(8'h45, 2);
    rd(8'h45, 3);
    wr(8'h20, 1);
    foreach (bad[i]) begin
      u_host.start_c();
      send({bad[i], 1'b0}, 1'b0);
      u_host.stop_c();
    end
    check_byte("seq_cmd", 8'(mem[24]), seq_cmd);
    check_byte("wakes", 8'(exp_wake), 8'(n_wake));
    for (int i = 0; i < 4; i++) begin
      @(negedge ref_clk);
      irq_req = i[0];
      repeat (2) @(negedge ref_clk);
      check_bit("int_oe", i[0], int_oe);
      check_bit("int_out", 1'b0, int_out);
    end
    // host fetches results only once the interrupt line is pulled
    check_bit("int_oe", 1'b1, int_oe);
    rd(8'h18, 2);
    @(negedge ref_clk);
    off_cmd = 1'b1;
    irq_req = 1'b1;
    repeat (3) @(negedge ref_clk);
    u_host.start_c();
    send({`SHRP_OWN_ADDR, 1'b0}, 1'b0);
    u_host.stop_c();
    check_bit("int_oe", 1'b0, int_oe);
    check_byte("pins", 8'h00, {4'h0, scl_out, sda_out, scl_oe, sda_oe});
    @(negedge ref_clk);
    off_cmd = 1'b0;
    irq_req = 1'b0;
    wait_ready();
    report_and_stop();
  end
endmodule : sensor_host_register_port_tb
